// >>> lwgs_pkg.sv
// constants and types for the laser write gate supervisor
// How it works
// R1 - on registration sensor turn-on, every colour's write gate is driven active.
// R2 - each laser unit's feedback idles high and falls when emission starts.
// R3 - feedback still high one second after write-start raises that colour's gate error.
// R4 - laser unit holds feedback low through exposure, high once the page ends.
// R5 - feedback still low seven seconds after exposure end raises gate timeout.
// R6 - feedback low when the next page's exposure is due also raises gate timeout.
// R7 - black homing: home sensor not on within five seconds raises a fault.
// R8 - after black pitch change: home sensor not off within five seconds raises fault.
// R9 - each timer counts clocks from its arming event, cleared by expected edge or reset.
// R10 - colours supervised independently; raised codes stay latched until reset.
package lwgs_pkg;

  localparam int unsigned LWGS_COLOURS = 4;
  localparam int unsigned LWGS_CNT_W = 30;
  localparam longint unsigned LWGS_CLK_PERIOD_NS = 64'd10;
  localparam longint unsigned LWGS_ERR_TIME_MS = 64'd1000;
  localparam longint unsigned LWGS_TMO_TIME_MS = 64'd7000;
  localparam longint unsigned LWGS_HOME_TIME_MS = 64'd5000;
  // longest times, so rounded down to whole cycles
  localparam longint unsigned LWGS_ERR_CYCLES = LWGS_ERR_TIME_MS * 64'd1000000 / LWGS_CLK_PERIOD_NS;
  localparam longint unsigned LWGS_TMO_CYCLES = LWGS_TMO_TIME_MS * 64'd1000000 / LWGS_CLK_PERIOD_NS;
  localparam longint unsigned LWGS_HOME_CYCLES = LWGS_HOME_TIME_MS * 64'd1000000 / LWGS_CLK_PERIOD_NS;
  localparam logic [LWGS_CNT_W-1:0] LWGS_CNT_RST = 30'h0;

  // colour order: 0 yellow, 1 magenta, 2 cyan, 3 black
  typedef logic [LWGS_CNT_W-1:0] lwgs_cnt_t;

  typedef enum logic [1:0] {
    HP_IDLE,
    HP_WAIT_ON,
    HP_WAIT_OFF
  } lwgs_hp_e;

  typedef struct packed {
    logic arm;
    lwgs_cnt_t cnt;
    logic fire;
  } lwgs_tmr_s;

  typedef struct packed {
    logic [LWGS_COLOURS-1:0] write_start;
    logic [LWGS_COLOURS-1:0] exposure_done;
    logic [LWGS_COLOURS-1:0] next_page_due;
    logic [LWGS_COLOURS-1:0] feedback;
  } lwgs_unit_in_s;

  typedef struct packed {
    logic [LWGS_COLOURS-1:0] gate_error_code;
    logic [LWGS_COLOURS-1:0] gate_timeout_code;
    logic home_on_fault;
    logic home_off_fault;
  } lwgs_codes_s;

endpackage

// >>> lwgs_supervisor.sv
// laser write gate supervision for four colours and home sensor supervision for black
`timescale 1ns/1ps
module lwgs_supervisor import lwgs_pkg::*; #(
  parameter int unsigned ERR_CYCLES = 32'(LWGS_ERR_CYCLES),
  parameter int unsigned TMO_CYCLES = 32'(LWGS_TMO_CYCLES),
  parameter int unsigned HOME_CYCLES = 32'(LWGS_HOME_CYCLES)
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic registration_sensor,
  input wire lwgs_unit_in_s unit_in,
  input wire logic homing_start,
  input wire logic pitch_changed,
  input wire logic home_position_sensor,
  output logic [LWGS_COLOURS-1:0] laser_write_gate,
  output lwgs_codes_s service_call_code
);

  typedef struct packed {
    logic reg_prev;
    logic [LWGS_COLOURS-1:0] gate;
    lwgs_tmr_s [LWGS_COLOURS-1:0] start_tmr;
    lwgs_tmr_s [LWGS_COLOURS-1:0] end_tmr;
    logic [LWGS_COLOURS-1:0] err;
    logic [LWGS_COLOURS-1:0] tmo;
    lwgs_hp_e hp_st;
    lwgs_tmr_s hp_tmr;
    logic hp_on_flt;
    logic hp_off_flt;
  } lwgs_state_s;

  lwgs_state_s state_ff;
  lwgs_state_s nxt_state;

  // one step of a supervision timer; fire is a one-cycle pulse at expiry
  function automatic lwgs_tmr_s tmr_step(lwgs_tmr_s cur, logic start, logic edge_seen, int unsigned limit);
    lwgs_tmr_s t;
    t = cur;
    t.fire = 1'b0;
    if (start) begin
      t.arm = 1'b1; // see R9
      t.cnt = LWGS_CNT_RST;
    end else if (cur.arm) begin
      if (edge_seen) begin
        t.arm = 1'b0; // see R9
        t.cnt = LWGS_CNT_RST;
      end else if (cur.cnt == LWGS_CNT_W'(limit - 1)) begin
        t.arm = 1'b0;
        t.fire = 1'b1;
      end else begin
        t.cnt = cur.cnt + 1'b1;
      end
    end
    return t;
  endfunction

  always_comb begin
    nxt_state = state_ff;
    nxt_state.reg_prev = registration_sensor;
    for (int c = 0; c < LWGS_COLOURS; c++) begin
      // gate opens on sensor turn-on, closes when the page is exposed
      if (registration_sensor && !state_ff.reg_prev) begin
        nxt_state.gate[c] = 1'b1; // see R1
      end else if (unit_in.exposure_done[c]) begin
        nxt_state.gate[c] = 1'b0;
      end
      // start watch: waits for feedback to fall
      nxt_state.start_tmr[c] = tmr_step(state_ff.start_tmr[c], unit_in.write_start[c],
                                        !unit_in.feedback[c], ERR_CYCLES); // see R3
      // end watch: waits for feedback to rise again
      nxt_state.end_tmr[c] = tmr_step(state_ff.end_tmr[c], unit_in.exposure_done[c],
                                      unit_in.feedback[c], TMO_CYCLES); // see R5
      // sticky per colour, never cleared by another colour
      if (nxt_state.start_tmr[c].fire) begin
        nxt_state.err[c] = 1'b1; // see R10
      end
      if (nxt_state.end_tmr[c].fire) begin
        nxt_state.tmo[c] = 1'b1; // see R5
      end
      // next page arrives while the previous exposure is still held low
      if (unit_in.next_page_due[c] && !unit_in.feedback[c] && state_ff.end_tmr[c].arm) begin
        nxt_state.tmo[c] = 1'b1; // see R6
        nxt_state.end_tmr[c].arm = 1'b0;
      end
    end
    // black positioning home sensor watch
    case (state_ff.hp_st)
      HP_IDLE: begin
        nxt_state.hp_tmr = tmr_step(state_ff.hp_tmr, homing_start | pitch_changed, 1'b0, HOME_CYCLES);
        if (homing_start) begin
          nxt_state.hp_st = HP_WAIT_ON;
        end else if (pitch_changed) begin
          nxt_state.hp_st = HP_WAIT_OFF;
        end
      end
      HP_WAIT_ON: begin
        nxt_state.hp_tmr = tmr_step(state_ff.hp_tmr, 1'b0, home_position_sensor, HOME_CYCLES);
        if (nxt_state.hp_tmr.fire) begin
          nxt_state.hp_on_flt = 1'b1; // see R7
        end
        if (!nxt_state.hp_tmr.arm) begin
          nxt_state.hp_st = HP_IDLE;
        end
      end
      HP_WAIT_OFF: begin
        nxt_state.hp_tmr = tmr_step(state_ff.hp_tmr, 1'b0, !home_position_sensor, HOME_CYCLES);
        if (nxt_state.hp_tmr.fire) begin
          nxt_state.hp_off_flt = 1'b1; // see R8
        end
        if (!nxt_state.hp_tmr.arm) begin
          nxt_state.hp_st = HP_IDLE;
        end
      end
      default: begin
        nxt_state.hp_st = HP_IDLE;
        nxt_state.hp_tmr = '0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0; // see R9
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign laser_write_gate = state_ff.gate;
  // one driver for the whole code struct
  assign service_call_code = '{gate_error_code: state_ff.err, gate_timeout_code: state_ff.tmo,
                               home_on_fault: state_ff.hp_on_flt, home_off_fault: state_ff.hp_off_flt};

  sequence s_reg_rise;
    !registration_sensor ##1 registration_sensor;
  endsequence

  property p_gate_on_reg;
    @(posedge clock) disable iff (!rst_n)
    s_reg_rise |=> (laser_write_gate == 4'hf);
  endproperty
  a_gate_on_reg: assert property (p_gate_on_reg) else $error("gate not opened on sensor turn-on"); // see R1

  sequence s_hp_on_expiry;
    (state_ff.hp_st == HP_WAIT_ON) && !home_position_sensor
      && (state_ff.hp_tmr.cnt == LWGS_CNT_W'(HOME_CYCLES - 1));
  endsequence

  property p_hp_on;
    @(posedge clock) disable iff (!rst_n)
    $rose(state_ff.hp_on_flt) |-> ($past(state_ff.hp_st) == HP_WAIT_ON) && !$past(home_position_sensor);
  endproperty
  a_hp_on: assert property (p_hp_on) else $error("home-on fault without expiry"); // see R7

  property p_hp_on_fires;
    @(posedge clock) disable iff (!rst_n)
    s_hp_on_expiry |=> service_call_code.home_on_fault && (state_ff.hp_st == HP_IDLE);
  endproperty
  a_hp_on_fires: assert property (p_hp_on_fires) else $error("home-on expiry not flagged"); // see R7

  property p_hp_off;
    @(posedge clock) disable iff (!rst_n)
    $rose(state_ff.hp_off_flt) |-> ($past(state_ff.hp_st) == HP_WAIT_OFF) && $past(home_position_sensor);
  endproperty
  a_hp_off: assert property (p_hp_off) else $error("home-off fault without expiry"); // see R8

  sequence s_hp_off_expiry;
    (state_ff.hp_st == HP_WAIT_OFF) && home_position_sensor
      && (state_ff.hp_tmr.cnt == LWGS_CNT_W'(HOME_CYCLES - 1));
  endsequence

  property p_hp_off_fires;
    @(posedge clock) disable iff (!rst_n)
    s_hp_off_expiry |=> service_call_code.home_off_fault && (state_ff.hp_st == HP_IDLE);
  endproperty
  a_hp_off_fires: assert property (p_hp_off_fires) else $error("home-off expiry not flagged"); // see R8

  for (genvar g = 0; g < LWGS_COLOURS; g++) begin : g_chk
    property p_err_cause;
      @(posedge clock) disable iff (!rst_n)
      $rose(state_ff.err[g]) |-> $past(state_ff.start_tmr[g].arm) && $past(unit_in.feedback[g])
        && ($past(state_ff.start_tmr[g].cnt) == LWGS_CNT_W'(ERR_CYCLES - 1));
    endproperty
    a_err_cause: assert property (p_err_cause) else $error("gate error without one second high"); // see R3

    property p_latched;
      @(posedge clock) disable iff (!rst_n)
      (state_ff.err[g] || state_ff.tmo[g]) |=> $stable(state_ff.err[g] | state_ff.tmo[g])
        && (state_ff.err[g] >= $past(state_ff.err[g])) && (state_ff.tmo[g] >= $past(state_ff.tmo[g]));
    endproperty
    a_latched: assert property (p_latched) else $error("service code dropped before reset"); // see R10

    property p_fall_clears;
      @(posedge clock) disable iff (!rst_n)
      state_ff.start_tmr[g].arm && !unit_in.feedback[g] && !unit_in.write_start[g]
        |=> !state_ff.start_tmr[g].arm && !$rose(state_ff.err[g]);
    endproperty
    a_fall_clears: assert property (p_fall_clears) else $error("feedback fall did not stop timer"); // see R9

    property p_arm_start;
      @(posedge clock) disable iff (!rst_n)
      unit_in.write_start[g] |=> state_ff.start_tmr[g].arm && (state_ff.start_tmr[g].cnt == LWGS_CNT_RST);
    endproperty
    a_arm_start: assert property (p_arm_start) else $error("write-start did not arm timer"); // see R9

    property p_tmo_cause;
      @(posedge clock) disable iff (!rst_n)
      $rose(state_ff.tmo[g]) |-> $past(state_ff.end_tmr[g].arm) && !$past(unit_in.feedback[g]);
    endproperty
    a_tmo_cause: assert property (p_tmo_cause) else $error("gate timeout without low feedback"); // see R5

    property p_next_page;
      @(posedge clock) disable iff (!rst_n)
      state_ff.end_tmr[g].arm && !unit_in.feedback[g] && unit_in.next_page_due[g]
        && !unit_in.exposure_done[g] |=> state_ff.tmo[g];
    endproperty
    a_next_page: assert property (p_next_page) else $error("next page with low feedback not flagged"); // see R6

    property p_err_fires;
      @(posedge clock) disable iff (!rst_n)
      state_ff.start_tmr[g].arm && unit_in.feedback[g] && !unit_in.write_start[g]
        && (state_ff.start_tmr[g].cnt == LWGS_CNT_W'(ERR_CYCLES - 1))
        |=> service_call_code.gate_error_code[g];
    endproperty
    a_err_fires: assert property (p_err_fires) else $error("start watch expiry not flagged"); // see R3

    property p_tmo_fires;
      @(posedge clock) disable iff (!rst_n)
      state_ff.end_tmr[g].arm && !unit_in.feedback[g] && !unit_in.exposure_done[g]
        && (state_ff.end_tmr[g].cnt == LWGS_CNT_W'(TMO_CYCLES - 1))
        |=> service_call_code.gate_timeout_code[g];
    endproperty
    a_tmo_fires: assert property (p_tmo_fires) else $error("end watch expiry not flagged"); // see R5

    // a sensor rise in the same cycle keeps the gate open
    property p_gate_close;
      @(posedge clock) disable iff (!rst_n)
      unit_in.exposure_done[g] && !(registration_sensor && !state_ff.reg_prev) |=> !laser_write_gate[g];
    endproperty
    a_gate_close: assert property (p_gate_close) else $error("gate not closed after exposure"); // see R1
  end

endmodule

// >>> lwgs_ld_model.sv
// behavioural laser unit feedback model for all four colours
`timescale 1ns/1ps
module lwgs_ld_model import lwgs_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [LWGS_COLOURS-1:0] laser_write_gate,
  input wire logic [LWGS_COLOURS-1:0] stuck_high,
  input wire logic [LWGS_COLOURS-1:0] stuck_low,
  output logic [LWGS_COLOURS-1:0] feedback
);
  // three cycles of beam start-up lag, well inside every watch
  logic [LWGS_COLOURS-1:0] gate_d1_ff;
  logic [LWGS_COLOURS-1:0] gate_d2_ff;
  logic [LWGS_COLOURS-1:0] gate_d3_ff;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gate_d1_ff <= '0;
      gate_d2_ff <= '0;
      gate_d3_ff <= '0;
    end else begin
      gate_d1_ff <= laser_write_gate;
      gate_d2_ff <= gate_d1_ff;
      gate_d3_ff <= gate_d2_ff;
    end
  end
  // idle high, low while emitting, high again after the page; faults only on command
  assign feedback = (~gate_d3_ff | stuck_high) & ~stuck_low;
endmodule

// >>> lwgs_supervisor_tb.sv
// self-checking bench for the laser write gate supervisor
`timescale 1ns/1ps
module lwgs_supervisor_tb import lwgs_pkg::*; ;
  localparam int unsigned ERR = 20;
  localparam int unsigned TMO = 40;
  localparam int unsigned HOME = 30;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic reg_sens = 1'b0;
  logic homing = 1'b0;
  logic pitch = 1'b0;
  logic home_sens = 1'b0;
  logic [3:0] ws = 4'h0;
  logic [3:0] ed = 4'h0;
  logic [3:0] npd = 4'h0;
  logic [3:0] stk_hi = 4'h0;
  logic [3:0] stk_lo = 4'h0;
  logic [3:0] fb;
  logic [3:0] gate;
  lwgs_unit_in_s unit_in;
  lwgs_codes_s codes;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  assign unit_in = '{write_start: ws, exposure_done: ed, next_page_due: npd, feedback: fb};
  always #5 clock = ~clock;
  lwgs_supervisor #(.ERR_CYCLES(ERR), .TMO_CYCLES(TMO), .HOME_CYCLES(HOME)) i_lwgs_supervisor (
    .clock(clock), .rst_n(rst_n), .registration_sensor(reg_sens), .unit_in(unit_in),
    .homing_start(homing), .pitch_changed(pitch), .home_position_sensor(home_sens),
    .laser_write_gate(gate), .service_call_code(codes));
  lwgs_ld_model i_lwgs_ld_model (.clock(clock), .rst_n(rst_n), .laser_write_gate(gate),
    .stuck_high(stk_hi), .stuck_low(stk_lo), .feedback(fb));
  task end_of_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      end_of_test();
    end
  end
  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task chk_gate(input string what, input logic [3:0] exp);
    n_tests++;
    if (gate !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, gate);
    end
  endtask
  // expected codes packed as error, timeout, home on, home off
  task chk_code(input string what, input logic [9:0] exp);
    n_tests++;
    if (codes !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, codes);
    end
  endtask
  task open_page(input logic [3:0] start);
    reg_sens = 1'b1;
    ws = start;
    step(1);
    ws = 4'h0;
    step(1);
    chk_gate("gate open", 4'hf);
    reg_sens = 1'b0;
    step(5);
  endtask
  task close_page();
    ed = 4'hf;
    step(1);
    ed = 4'h0;
    step(2);
    chk_gate("gate closed", 4'h0);
  endtask
  task t_normal();
    open_page(4'hf);
    step(ERR);
    close_page();
    step(TMO + 10);
    chk_code("clean page", 10'h000);
  endtask
  task t_err();
    stk_hi = 4'h2;
    open_page(4'hf);
    step(ERR - 9);
    chk_code("error early", 10'h000);
    step(12);
    chk_code("error magenta", {4'h2, 4'h0, 2'b00});
    close_page();
    step(TMO + 10);
    chk_code("no timeout", {4'h2, 4'h0, 2'b00});
  endtask
  task t_tmo();
    open_page(4'h0);
    stk_lo = 4'h4;
    close_page();
    step(TMO - 4);
    chk_code("timeout early", {4'h2, 4'h0, 2'b00});
    step(8);
    chk_code("timeout cyan", {4'h2, 4'h4, 2'b00});
  endtask
  task t_next();
    open_page(4'h0);
    stk_lo = 4'hc;
    ed = 4'hf;
    step(1);
    ed = 4'h0;
    step(4);
    chk_code("before next page", {4'h2, 4'h4, 2'b00});
    npd = 4'h8;
    step(1);
    npd = 4'h0;
    step(1);
    chk_code("next page black", {4'h2, 4'hc, 2'b00});
  endtask
  task t_home();
    homing = 1'b1;
    step(1);
    homing = 1'b0;
    step(5);
    home_sens = 1'b1;
    step(HOME + 5);
    chk_code("homing ok", {4'h2, 4'hc, 2'b00});
    pitch = 1'b1;
    step(1);
    pitch = 1'b0;
    step(HOME - 4);
    chk_code("pitch early", {4'h2, 4'hc, 2'b00});
    step(8);
    chk_code("pitch stuck", {4'h2, 4'hc, 2'b01});
    home_sens = 1'b0;
    step(2);
    homing = 1'b1;
    step(1);
    homing = 1'b0;
    step(HOME + 6);
    chk_code("homing stuck", {4'h2, 4'hc, 2'b11});
  endtask
  task t_reset();
    stk_hi = 4'h0;
    stk_lo = 4'h0;
    rst_n = 1'b0;
    step(2);
    chk_code("codes in reset", 10'h000);
    rst_n = 1'b1;
    step(2);
    chk_code("codes after reset", 10'h000);
    chk_gate("gate after reset", 4'h0);
  endtask
  initial begin
    step(16);
    rst_n = 1'b1;
    step(1);
    t_normal();
    t_err();
    t_tmo();
    t_next();
    t_home();
    t_reset();
    t_normal();
    end_of_test();
  end
endmodule
